// File: verilog/adc_out_consts.vh
// constants for the converter parallel output and reset block
// Functional notes
// [RL1] low select enables internal reference generators
// [RL2] results are 18-bit two's complement words
// [RL3] normal codes clip at 200A8h and 1FF57h
// [RL4] step transients clip 1FFFFh/20000h, flag set
// [RL5] zero gives 00000h, steps 00001h/3FFFFh
// [RL6] over-range flag rises at data-ready fall
// [RL7] flag clears at data-ready fall when back
// [RL8] data-ready falling edge marks new result
// [RL9] bus driven only when select and read low
// [RL10] buffered mode: host must toggle read strobe
// [RL11] unbuffered reset clears logic, bus low, ready high
// [RL12] data-ready low second rising edge after release
// [RL13] host discards 46 periods after unbuffered reset
// [RL14] common reset edge gives lockstep devices
// [RL15] buffered reset completes with a read toggle
// [RL16] buffered settling is fixed clock count
// [RL17] host waits per-depth settling periods
// [RL18] clock must run continuously
// [RL19] depth twice select; period 32 times depth
// [RL20] full buffer pulses ready; oldest read first
`ifndef ADC_OUT_CONSTS_VH
`define ADC_OUT_CONSTS_VH
`define DATA_W 18
`define CODE_NORM_MAX 18'h1_FF57
`define CODE_NORM_MIN 18'h2_00A8
`define CODE_STEP_MAX 18'h1_FFFF
`define CODE_STEP_MIN 18'h2_0000
`define BASE_PERIOD 10'h020
`define SETTLE_CLKS 6'h2E
`define SKIP_PERIOD 10'h200
`endif

// File: verilog/adc_parallel_output_reset.v
// converter digital output: coding, over-range, data-ready, bus, buffer, reset
`timescale 1ns/10ps
`include "adc_out_consts.vh"
module adc_parallel_output_reset #(
  parameter DEPTH_MAX = 14
) (
  input wire CLK, // converter clock, 50 MHz
  input wire RST_N, // synchronous reset, active low
  input wire [`DATA_W-1:0] SAMPLE_IN, // raw filter result, same clock
  input wire SAMPLE_VALID, // one-cycle pulse per filter result
  input wire STEP_TRANSIENT, // filter reports large step
  input wire REFERENCE_SOURCE_SELECT_N, // pin: low selects internal reference
  input wire [2:0] BUFFER_DEPTH_SELECT, // pin: buffer depth select
  input wire CS_N, // pin: chip select
  input wire RD_N, // pin: read strobe
  output reg INT_REF_ENABLE, // internal reference generators on
  output reg [`DATA_W-1:0] DOUT_O, // output bus value
  output reg DOUT_OE, // output bus enable
  output reg DATA_READY_N, // data ready, active low
  output reg OVER_RANGE_FLAG, // out-of-range flag
  output reg SETTLED // filter settling elapsed (buffered); first result seen (unbuffered)
);
  localparam ST_RESET = 3'b001;
  localparam ST_WAIT_RD = 3'b010;
  localparam ST_RUN = 3'b100;

  // code limiting and over-range detection
  function [`DATA_W:0] limit_code;
    input [`DATA_W-1:0] raw;
    input step;
    reg signed [`DATA_W-1:0] s;
    begin
      s = raw;
      limit_code = {1'b0, raw};
      if (step && !s[`DATA_W-1])
        limit_code = {1'b1, `CODE_STEP_MAX};
      else if (step)
        limit_code = {1'b1, `CODE_STEP_MIN};
      else if (s > $signed(`CODE_NORM_MAX))
        limit_code = {1'b0, `CODE_NORM_MAX};
      else if (s < $signed(`CODE_NORM_MIN))
        limit_code = {1'b0, `CODE_NORM_MIN};
    end
  endfunction

  reg ref_s1_r, ref_s2_r, cs_s1_r, cs_s2_r, rd_s1_r, rd_s2_r, rd_d_r;
  reg [2:0] dep_s1_r, dep_s2_r;
  reg [2:0] state_r;
  reg [`DATA_W-1:0] mem_r [0:DEPTH_MAX-1];
  reg [3:0] wr_cnt_r, rd_idx_r;
  reg [9:0] per_cnt_r;
  reg [`DATA_W-1:0] word_r;
  reg otr_pend_r;
  reg [5:0] settle_r;
  reg [1:0] rel_r;
  wire [`DATA_W:0] lim = limit_code(SAMPLE_IN, STEP_TRANSIENT);
  wire buffered = (dep_s2_r != 3'b000);
  wire [3:0] depth = {dep_s2_r, 1'b0};
  wire [9:0] period = buffered ? `BASE_PERIOD * {7'd0, dep_s2_r} * 10'd2 : `BASE_PERIOD;
  wire rd_fall = rd_d_r && !rd_s2_r;
  integer i;

  // pin synchronisers
  always @(posedge CLK)
  begin
    ref_s1_r <= REFERENCE_SOURCE_SELECT_N;
    ref_s2_r <= ref_s1_r;
    cs_s1_r <= CS_N;
    cs_s2_r <= cs_s1_r;
    rd_s1_r <= RD_N;
    rd_s2_r <= rd_s1_r;
    rd_d_r <= rd_s2_r;
    dep_s1_r <= BUFFER_DEPTH_SELECT;
    dep_s2_r <= dep_s1_r;
  end

  // main sequencer
  always @(posedge CLK)
  begin
    // [RL1] reference enable
    INT_REF_ENABLE <= !ref_s2_r;
    if (!RST_N)
    begin
      // [RL11] reset clears outputs and sets ready high; INT_REF_ENABLE keeps following the pin
      // [RL14] common reset edge aligns devices
      state_r <= ST_RESET;
      DOUT_O <= 18'h0_0000;
      DOUT_OE <= 1'b0;
      DATA_READY_N <= 1'b1;
      OVER_RANGE_FLAG <= 1'b0;
      SETTLED <= 1'b0;
      wr_cnt_r <= 4'h0;
      rd_idx_r <= 4'h0;
      per_cnt_r <= 10'h000;
      word_r <= 18'h0_0000;
      otr_pend_r <= 1'b0;
      settle_r <= 6'h00;
      rel_r <= 2'b00;
      for (i = 0; i < DEPTH_MAX; i = i + 1)
        mem_r[i] <= 18'h0_0000;
    end
    else
    begin
      // [RL9] bus enable gating
      DOUT_OE <= !cs_s2_r && !rd_s2_r && (state_r == ST_RUN);
      case (state_r)
        ST_RESET:
        begin
          // [RL12] ready low second edge
          rel_r <= rel_r + 2'b01;
          if (rel_r == 2'b01)
          begin
            DATA_READY_N <= 1'b0;
            // [RL15] buffered waits for read
            state_r <= buffered ? ST_WAIT_RD : ST_RUN;
          end
        end
        ST_WAIT_RD:
        begin
          if (rd_fall)
            state_r <= ST_RUN;
        end
        ST_RUN:
        begin
          // [RL16] fixed clock settling
          if (settle_r != `SETTLE_CLKS)
            settle_r <= settle_r + 6'h01;
          else if (buffered)
            SETTLED <= 1'b1;
          if (SAMPLE_VALID)
          begin
            // [RL2] [RL3] [RL4] [RL5] limited code
            if (!buffered)
            begin
              word_r <= lim[`DATA_W-1:0];
              otr_pend_r <= lim[`DATA_W];
              // [RL8] ready falls with new result
              DATA_READY_N <= 1'b0;
              // [RL6] [RL7] flag at ready fall
              OVER_RANGE_FLAG <= lim[`DATA_W];
              DOUT_O <= lim[`DATA_W-1:0];
              SETTLED <= 1'b1;
            end
            else if (wr_cnt_r < depth)
            begin
              mem_r[wr_cnt_r] <= lim[`DATA_W-1:0];
              wr_cnt_r <= wr_cnt_r + 4'h1;
              if (lim[`DATA_W])
                otr_pend_r <= 1'b1;
            end
          end
          else if (!buffered)
            DATA_READY_N <= 1'b1;
          // [RL19] period counter
          if (buffered)
          begin
            per_cnt_r <= per_cnt_r + 10'h001;
            // [RL20] full buffer pulses ready
            if (wr_cnt_r == depth && rd_idx_r == 4'h0 && per_cnt_r >= period - 10'h001)
            begin
              DATA_READY_N <= 1'b1;
              per_cnt_r <= 10'h000;
            end
            else if (!DATA_READY_N || per_cnt_r >= `SKIP_PERIOD)
            begin
              if (per_cnt_r >= `SKIP_PERIOD)
                per_cnt_r <= 10'h000;
            end
            else
            begin
              DATA_READY_N <= 1'b0;
              OVER_RANGE_FLAG <= otr_pend_r;
              // a new over-range word in the same cycle wins over the clear
              otr_pend_r <= SAMPLE_VALID && (wr_cnt_r < depth) && lim[`DATA_W];
            end
            // [RL20] oldest word first per read fall
            if (rd_fall && wr_cnt_r == depth)
            begin
              DOUT_O <= mem_r[rd_idx_r];
              if (rd_idx_r == depth - 4'h1)
              begin
                rd_idx_r <= 4'h0;
                wr_cnt_r <= 4'h0;
              end
              else
                rd_idx_r <= rd_idx_r + 4'h1;
            end
          end
        end
        default:
          state_r <= ST_RESET;
      endcase
    end
  end
endmodule

// File: verification/adc_out_props.sv
// port assertions for the converter output block
`timescale 1ns/10ps
module adc_out_props (
  input wire CLK, // clk
  input wire RST_N, // rst
  input wire SAMPLE_VALID, // vld
  input wire STEP_TRANSIENT, // step
  input wire REFERENCE_SOURCE_SELECT_N, // ref
  input wire [2:0] BUFFER_DEPTH_SELECT, // dep
  input wire CS_N, // cs
  input wire RD_N, // rd
  input wire INT_REF_ENABLE, // ref on
  input wire [17:0] DOUT_O, // bus
  input wire DOUT_OE, // oe
  input wire DATA_READY_N, // rdy
  input wire OVER_RANGE_FLAG // flag
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // result checks hold in unbuffered mode
  wire u = BUFFER_DEPTH_SELECT == 3'h0;
  property p_rdy; u && $past(SAMPLE_VALID) |-> !DATA_READY_N; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_cod; u && $past(SAMPLE_VALID && !STEP_TRANSIENT) |-> !OVER_RANGE_FLAG &&
    $signed(DOUT_O) <= $signed(18'h1_FF57) && $signed(DOUT_O) >= $signed(18'h2_00A8);
  endproperty
  a_cod: assert property (p_cod) else $error("code range");
  property p_stp; u && $past(SAMPLE_VALID && STEP_TRANSIENT) |-> OVER_RANGE_FLAG &&
    (DOUT_O == 18'h1_FFFF || DOUT_O == 18'h2_0000); endproperty
  a_stp: assert property (p_stp) else $error("step clip");
  property p_flg; $changed(OVER_RANGE_FLAG) |-> !DATA_READY_N; endproperty
  a_flg: assert property (p_flg) else $error("flag moved");
  property p_off; (CS_N || RD_N) [*5] |-> !DOUT_OE; endproperty
  a_off: assert property (p_off) else $error("bus on");
  property p_on; (u && !CS_N && !RD_N) [*5] |-> DOUT_OE; endproperty
  a_on: assert property (p_on) else $error("bus off");
  property p_ref; $stable(REFERENCE_SOURCE_SELECT_N) [*5] |->
    INT_REF_ENABLE == !REFERENCE_SOURCE_SELECT_N; endproperty
  a_ref: assert property (p_ref) else $error("ref enable");
  property p_rst; disable iff (1'b0) !RST_N |=> DATA_READY_N && !DOUT_OE &&
    !OVER_RANGE_FLAG && DOUT_O == 18'h0_0000; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule
bind adc_parallel_output_reset adc_out_props CHK (.*);

// File: verification/host_model.sv
// host model strobing select and read
`timescale 1ns/10ps
module host_model (
  input wire clk, // clock
  input wire en, // reading
  output reg cs_n = 1'b1, // select
  output reg rd_n = 1'b1 // read
);
  reg [2:0] n = 3'h0;
  always @(posedge clk)
  begin
    n <= n + 3'h1;
    cs_n <= ~en;
    rd_n <= (n == 3'h7) ? ~en | ~rd_n : rd_n | ~en;
  end
endmodule

// File: verification/adc_parallel_output_reset_tb_top.sv
// bench for the converter output block
`timescale 1ns/10ps
`include "adc_out_consts.vh"
module adc_parallel_output_reset_tb_top;
  reg clk = 0, rst_n = 0, vld = 0, stp = 0, rsel = 0, hen = 0;
  reg [17:0] raw = 0;
  reg [2:0] dep = 3'h0;
  wire setl;
  reg [31:0] sd = 32'h6919_56e4;
  reg [18:0] q[$];
  wire [17:0] dout;
  wire oe, rdy_n, ovr, iref, cs_n, rd_n;
  integer n_errors = 0, num_checks = 0, i, k;
  initial forever #10 clk = ~clk;
  host_model HOST (.clk(clk), .en(hen), .cs_n(cs_n), .rd_n(rd_n));
  adc_parallel_output_reset DUT (.CLK(clk), .RST_N(rst_n), .SAMPLE_IN(raw),
    .SAMPLE_VALID(vld), .STEP_TRANSIENT(stp), .REFERENCE_SOURCE_SELECT_N(rsel),
    .BUFFER_DEPTH_SELECT(dep), .CS_N(cs_n), .RD_N(rd_n), .INT_REF_ENABLE(iref),
    .DOUT_O(dout), .DOUT_OE(oe), .DATA_READY_N(rdy_n), .OVER_RANGE_FLAG(ovr), .SETTLED(setl));
  function [31:0] xs(input [31:0] x);
  begin
    xs = x ^ (x << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  end
  endfunction
  task tw(input integer c);
    repeat (c) @(posedge clk) #1;
  endtask
  task test_done;
  begin
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task chk(input [31:0] nm, input [18:0] e, input [18:0] s);
  begin
    num_checks = num_checks + 1;
    if (e !== s)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0s exp %h got %h", nm, e, s);
    end
  end
  endtask
  // a bounded wait that ran out ends the run
  task tmo(input integer c, input integer lim);
  begin
    if (c == lim)
    begin
      n_errors = n_errors + 1;
      $display("[FAIL] wait exp done got timeout");
      test_done;
    end
  end
  endtask
  // release reset on a falling edge, ready low at second rising edge
  task rel;
  begin
    @(negedge clk);
    rst_n = 1;
    tw(1);
    chk("rdy1", 1, rdy_n);
    tw(1);
    chk("rdy0", 0, rdy_n);
  end
  endtask
  // model the clipped code and pulse one result in
  task put(input [17:0] r, input s);
  begin
    if (s)
      q.push_back({1'b1, r[17] ? `CODE_STEP_MIN : `CODE_STEP_MAX});
    else if ($signed(r) > 130903 || $signed(r) < -130904)
      q.push_back({1'b0, r[17] ? `CODE_NORM_MIN : `CODE_NORM_MAX});
    else
      q.push_back({1'b0, r});
    raw = r;
    stp = s;
    vld = 1;
    tw(1);
    vld = 0;
  end
  endtask
  // send one unbuffered result, compare at ready
  task send(input [17:0] r, input s);
  begin
    put(r, s);
    for (i = 0; rdy_n !== 1'b0 && i < 8; i = i + 1)
      tw(1);
    tmo(i, 8);
    chk("dout", q.pop_front(), {ovr, dout});
    tw(3);
  end
  endtask
  initial
  begin
    tw(16);
    // filter settling is outside this block; settled flag checked
    rel;
    chk("setl", 0, setl);
    tw(6);
    send(18'h0_0001, 0);
    chk("setl", 1, setl);
    send(18'h3_FFFF, 0);
    send(18'h1_FF58, 0);
    send(18'h2_00A7, 0);
    send(18'h1_FF00, 1);
    send(18'h0_0000, 0);
    for (k = 0; k < 60; k = k + 1)
    begin
      sd = xs(sd);
      send(sd[17:0], sd[31] & sd[30]);
    end
    send(18'h3_0000, 1);
    rst_n = 0;
    tw(2);
    chk("rstv", 19'h4_0000, {rdy_n, dout});
    chk("rstf", 0, {oe, ovr});
    chk("setl", 0, setl);
    // reset pulse released on a falling edge
    rel;
    tw(6);
    send(18'h0_1234, 0);
    rsel = 1;
    tw(6);
    chk("ref", 0, iref);
    rsel = 0;
    tw(6);
    chk("ref", 1, iref);
    hen = 1;
    for (i = 0; rd_n !== 1'b0 && i < 20; i = i + 1)
      tw(1);
    tmo(i, 20);
    tw(5);
    chk("oe", 1, oe);
    hen = 0;
    tw(6);
    chk("oe", 0, oe);
    dep = 3'h1;
    rst_n = 0;
    tw(4);
    // buffered release on rising edge, then a read toggle
    rst_n = 1;
    tw(2);
    chk("rdyb", 0, rdy_n);
    hen = 1;
    for (i = 0; rd_n !== 1'b0 && i < 20; i = i + 1)
      tw(1);
    tmo(i, 20);
    tw(4);
    hen = 0;
    tw(2);
    chk("setl", 0, setl);
    put(18'h0_0011, 0);
    put(18'h3_FF00, 0);
    for (i = 0; rdy_n !== 1'b1 && i < 600; i = i + 1)
      tw(1);
    tmo(i, 600);
    // read only after the full-buffer pulse
    hen = 1;
    for (k = 0; k < 2; k = k + 1)
    begin
      for (i = 0; rd_n !== 1'b1 && i < 20; i = i + 1)
        tw(1);
      tmo(i, 20);
      for (i = 0; rd_n !== 1'b0 && i < 20; i = i + 1)
        tw(1);
      tmo(i, 20);
      tw(4);
      chk("dout", q.pop_front(), {ovr, dout});
      chk("oe", 1, oe);
    end
    hen = 0;
    chk("setl", 1, setl);
    test_done;
  end
endmodule
